// ==== logic/scpm_cfg.svh ====
/*
 * constants of the system clock and power mode controller: register
 * offsets, field positions, reset values and select codes.
 * assumes it is included by bare name from the design and the testbench.
 */
`ifndef SCPM_CFG_SVH
`define SCPM_CFG_SVH

// ****************************************************************
// register byte offsets on the wishbone bus
// ****************************************************************
`define SCPM_OFS_SYSCLK      8'h00
`define SCPM_OFS_FAST_RC     8'h04
`define SCPM_OFS_FAST_XTAL   8'h08
`define SCPM_OFS_SLOW_XTAL   8'h0C

// ****************************************************************
// reset values
// ****************************************************************
`define SCPM_RST_SYSCLK      8'h00
`define SCPM_RST_FAST_RC     8'h01
`define SCPM_RST_FAST_XTAL   8'h00
`define SCPM_RST_SLOW_XTAL   8'h00

// ****************************************************************
// field codes
// ****************************************************************
`define SCPM_SEL_SLOW        3'h7
`define SCPM_RC_FREQ_4M      2'h0
`define SCPM_RC_FREQ_ALIAS   2'h3
`define SCPM_OSC_FAST_RC     0
`define SCPM_OSC_FAST_XTAL   1
`define SCPM_OSC_SLOW_XTAL   2
`define SCPM_OSC_SLOW_RC     3

// ****************************************************************
// field positions and write masks
// ****************************************************************
`define SCPM_BIT_ENABLE      0
`define SCPM_BIT_RANGE       2
`define SCPM_RC_FREQ_LSB     2
`define SCPM_SYSCLK_WMASK    8'hEF

`endif

// ==== logic/scpm_ctrl.sv ====
/*
 * system clock select, prescaler, oscillator enables, stable flags
 * and halt power modes, with a classic wishbone register slave.
 * assumes oscillator levels and ready indications arrive
 * asynchronously and are sampled by the 20 MHz clk_i; halt_i,
 * wake_i and wdt_enable_i come from logic on clk_i.
 */
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "scpm_cfg.svh"

// Notes on behaviour
// - halt with both idle bits low: sleep
// - sleep keeps slow rc when watchdog enabled
// - halt, fast 0 slow 1: idle slow only
// - halt, both idle bits: idle both clocks
// - halt, fast 1 slow 0: idle fast only
// - select picks fh divided or fsub
// - fast source: rc or crystal
// - slow source: rc or crystal
// - fast idle bit keeps a fast oscillator whose enable bit is set
// - slow idle bit; watchdog keeps slow rc
// - rc frequency code, 11 aliases 4MHz
// - rc stable flag clears then sets
// - rc enable controls oscillator, resets on
// - crystal range bit selects 10MHz band
// - fast crystal stable clears then sets
// - slow crystal stable clears then sets
// - crystal enables start oscillators, reset off
// - select changes speed; idle bits pick mode
// - switch to fsub waits for stability
// - fast oscillator restarts for full speed
// - unimplemented bits read zero
// - fh after slow switch follows enable
module scpm_ctrl
  import scpm_pkg::*;
#(
  parameter int AW = 8    // wishbone address width
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // cpu and watchdog
  input  wire logic          halt_i,
  input  wire logic          wake_i,
  input  wire logic          wdt_enable_i,
  output logic               cpu_run_o,
  // oscillator levels and ready indications (asynchronous)
  input  wire logic [3:0]    osc_level_i,
  input  wire logic [3:0]    osc_ready_i,
  // oscillator controls
  output logic [3:0]         osc_run_o,
  output logic [1:0]         fast_rc_freq_o,
  output logic               fast_crystal_range_o,
  // clocks out
  output logic               sysclk_o,
  output logic               fh_periph_o,
  output logic               fsub_periph_o
);

  // ****************************************************************
  // registers
  // ****************************************************************
  scpm_sysclk_t sysclk_ctl;        // system clock control
  logic [1:0]   fast_rc_freq_select;
  logic         fast_rc_enable;
  logic         fast_crystal_range;
  logic         fast_crystal_enable;
  logic         slow_crystal_enable;
  logic [2:0]   stable;            // rc, fast crystal, slow crystal
  scpm_mode_t   mode;              // cpu power mode
  logic [3:0]   run_q;             // run outputs one cycle late
  logic [3:0]   sync1;             // first synchroniser stage
  logic [3:0]   sync2;             // second synchroniser stage
  logic [3:0]   rdy1;
  logic [3:0]   rdy2;
  logic         fh_q;              // previous fh level for edge
  logic [5:0]   presc;             // free running prescaler
  logic [2:0]   act_sel;           // tap now driving sysclk_o
  logic [3:0]   next_run;
  logic [7:0]   tap;
  logic         fh_lvl;
  logic         fsub_lvl;
  logic         slow_ok;
  logic         halted;
  logic         fh_need;
  logic         fsub_need;
  logic         wr;
  logic         rd_hit;
  logic [7:0]   rd_byte;

  assign halted = (mode != SCPM_RUN);
  assign wr     = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];

  // ****************************************************************
  // synchronisers: two flops for every asynchronous input
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      // first stage read only by the second
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          rdy1[g]  <= 1'b0;
          rdy2[g]  <= 1'b0;
        end else begin
          sync1[g] <= osc_level_i[g];
          sync2[g] <= sync1[g];
          rdy1[g]  <= osc_ready_i[g];
          rdy2[g]  <= rdy1[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // wishbone ack: one cycle after the strobe, then dropped
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // ****************************************************************
  // control register writes
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysclk_ctl          <= scpm_sysclk_t'(`SCPM_RST_SYSCLK);
      // reset bytes are cut down to each field on purpose
      fast_rc_freq_select <= 2'(`SCPM_RST_FAST_RC >> `SCPM_RC_FREQ_LSB);
      fast_rc_enable      <= 1'(`SCPM_RST_FAST_RC >> `SCPM_BIT_ENABLE);
      fast_crystal_range  <= 1'(`SCPM_RST_FAST_XTAL >> `SCPM_BIT_RANGE);
      fast_crystal_enable <= 1'(`SCPM_RST_FAST_XTAL >> `SCPM_BIT_ENABLE);
      slow_crystal_enable <= 1'(`SCPM_RST_SLOW_XTAL >> `SCPM_BIT_ENABLE);
    end else if (wr) begin
      case (adr_i)
        `SCPM_OFS_SYSCLK: begin
          // reserved bit 4 never stores anything
          sysclk_ctl <= scpm_sysclk_t'(dat_i[7:0] & `SCPM_SYSCLK_WMASK);
        end
        `SCPM_OFS_FAST_RC: begin
          fast_rc_freq_select <= dat_i[`SCPM_RC_FREQ_LSB +: 2];
          fast_rc_enable      <= dat_i[`SCPM_BIT_ENABLE];
        end
        `SCPM_OFS_FAST_XTAL: begin
          // range is locked while the crystal enable bit is set, so a stray write
          // cannot retune a crystal started by its enable bit, but one forced on as the selected source stays unlocked
          if (!fast_crystal_enable) begin
            fast_crystal_range <= dat_i[`SCPM_BIT_RANGE];
          end
          fast_crystal_enable <= dat_i[`SCPM_BIT_ENABLE];
        end
        `SCPM_OFS_SLOW_XTAL: begin
          slow_crystal_enable <= dat_i[`SCPM_BIT_ENABLE];
        end
        default: begin
          // unmapped write: acknowledged and dropped
        end
      endcase
    end
  end

  // ****************************************************************
  // register read data, registered with the ack
  // ****************************************************************
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (adr_i)
      `SCPM_OFS_SYSCLK:    rd_byte = sysclk_ctl;
      `SCPM_OFS_FAST_RC:   rd_byte = {4'h0, fast_rc_freq_select, stable[0],
                                      fast_rc_enable};
      `SCPM_OFS_FAST_XTAL: rd_byte = {5'h00, fast_crystal_range, stable[1],
                                      fast_crystal_enable};
      `SCPM_OFS_SLOW_XTAL: rd_byte = {6'h00, stable[2], slow_crystal_enable};
      default:             rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_o & ~we_i) begin
      // unmapped reads return zero
      dat_o <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // power mode: halt chooses purely from the idle bits
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= SCPM_RUN;
    end else begin
      case (mode)
        SCPM_RUN: begin
          if (halt_i) begin
            case ({sysclk_ctl.fast_idle_enable, sysclk_ctl.slow_idle_enable})
              2'b00:   mode <= SCPM_SLEEP;
              2'b01:   mode <= SCPM_IDLE_SLOW_ONLY;
              2'b11:   mode <= SCPM_IDLE_BOTH_CLOCKS;
              default: mode <= SCPM_IDLE_FAST_ONLY;
            endcase
          end
        end
        default: begin
          if (wake_i) begin
            mode <= SCPM_RUN;
          end
        end
      endcase
    end
  end

  assign cpu_run_o = ~halted;

  // ****************************************************************
  // oscillator run decisions
  // ****************************************************************
  always_comb begin
    fh_need   = ~halted | sysclk_ctl.fast_idle_enable;
    fsub_need = ~halted | sysclk_ctl.slow_idle_enable;
    // in run mode on a fast tap the chosen source is forced on
    next_run[`SCPM_OSC_FAST_RC] = fh_need & (fast_rc_enable |
      (~halted & ~sysclk_ctl.fast_source_select &
       (sysclk_ctl.sysclk_select != `SCPM_SEL_SLOW)));
    // on fsub the fast oscillator follows its own enable bit
    next_run[`SCPM_OSC_FAST_XTAL] = fh_need & (fast_crystal_enable |
      (~halted & sysclk_ctl.fast_source_select &
       (sysclk_ctl.sysclk_select != `SCPM_SEL_SLOW)));
    next_run[`SCPM_OSC_SLOW_XTAL] = fsub_need &
      (slow_crystal_enable | sysclk_ctl.slow_source_select);
    // watchdog keeps the slow rc alive even in sleep
    next_run[`SCPM_OSC_SLOW_RC] = fsub_need | wdt_enable_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_run_o <= 4'h0;
      run_q     <= 4'h0;
    end else begin
      osc_run_o <= next_run;
      run_q     <= osc_run_o;
    end
  end

  // ****************************************************************
  // stable flags: cleared on the start edge, set on ready
  // ****************************************************************
  generate
    for (g = 0; g < 3; g++) begin : g_stable
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stable[g] <= 1'b0;
        end else if (!osc_run_o[g] || !run_q[g]) begin
          stable[g] <= 1'b0;
        end else if (rdy2[g]) begin
          stable[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // oscillator tuning outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_rc_freq_o       <= `SCPM_RC_FREQ_4M;
      fast_crystal_range_o <= 1'b0;
    end else begin
      // code 11 is an alias of the 4 MHz setting
      fast_rc_freq_o <= (fast_rc_freq_select == `SCPM_RC_FREQ_ALIAS) ?
                        `SCPM_RC_FREQ_4M : fast_rc_freq_select;
      fast_crystal_range_o <= fast_crystal_range;
    end
  end

  // ****************************************************************
  // source selection and prescaler
  // ****************************************************************
  // note: sources are sampled at 20 MHz, so only oscillators well below
  // half that rate are reproduced faithfully; the trade buys one domain
  assign fh_lvl   = sysclk_ctl.fast_source_select ?
                    sync2[`SCPM_OSC_FAST_XTAL] : sync2[`SCPM_OSC_FAST_RC];
  assign fsub_lvl = sysclk_ctl.slow_source_select ?
                    sync2[`SCPM_OSC_SLOW_XTAL] : sync2[`SCPM_OSC_SLOW_RC];
  assign slow_ok  = sysclk_ctl.slow_source_select ? stable[2] :
                    rdy2[`SCPM_OSC_SLOW_RC];

  // prescaler counts every fh rising edge and never resets on select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fh_q  <= 1'b0;
      presc <= 6'h00;
    end else begin
      fh_q <= fh_lvl;
      if (fh_lvl && !fh_q) begin
        presc <= presc + 6'h01;
      end
    end
  end

  // tap 0 is fh itself, tap n is fh / 2^n, tap 7 is fsub
  assign tap = {fsub_lvl, presc, fh_lvl};

  // ****************************************************************
  // glitch free system clock multiplexer
  // ****************************************************************
  // the tap only changes while old and new taps are both low, so no
  // shortened high phase can ever reach sysclk_o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_sel  <= 3'h0;
      sysclk_o <= 1'b0;
    end else begin
      if (act_sel != sysclk_ctl.sysclk_select && !sysclk_o &&
          !tap[sysclk_ctl.sysclk_select] &&
          (sysclk_ctl.sysclk_select != `SCPM_SEL_SLOW || slow_ok)) begin
        act_sel  <= sysclk_ctl.sysclk_select;
        sysclk_o <= 1'b0;
      end else begin
        sysclk_o <= tap[act_sel];
      end
    end
  end

  // ****************************************************************
  // peripheral clocks, gated by the power mode
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fh_periph_o   <= 1'b0;
      fsub_periph_o <= 1'b0;
    end else begin
      fh_periph_o   <= fh_lvl & fh_need;
      fsub_periph_o <= fsub_lvl & fsub_need;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sleep_entry: assert property ((mode == SCPM_RUN) && halt_i &&
      !sysclk_ctl.fast_idle_enable && !sysclk_ctl.slow_idle_enable
      |=> (mode == SCPM_SLEEP) ##1 !fsub_periph_o)
    else $error("halt with idle bits low did not sleep");
  a_sleep_wdt_rc: assert property ((mode == SCPM_SLEEP) && wdt_enable_i
      |=> osc_run_o[`SCPM_OSC_SLOW_RC])
    else $error("slow rc stopped in sleep with watchdog on");
  a_idle_slow: assert property ((mode == SCPM_RUN) && halt_i &&
      !sysclk_ctl.fast_idle_enable && sysclk_ctl.slow_idle_enable
      |=> (mode == SCPM_IDLE_SLOW_ONLY))
    else $error("idle slow only not entered");
  a_idle_both: assert property ((mode == SCPM_RUN) && halt_i &&
      sysclk_ctl.fast_idle_enable && sysclk_ctl.slow_idle_enable
      |=> (mode == SCPM_IDLE_BOTH_CLOCKS))
    else $error("idle both clocks not entered");
  a_idle_fast: assert property ((mode == SCPM_RUN) && halt_i &&
      sysclk_ctl.fast_idle_enable && !sysclk_ctl.slow_idle_enable
      |=> (mode == SCPM_IDLE_FAST_ONLY))
    else $error("idle fast only not entered");
  a_fast_off_halt: assert property (halted && !sysclk_ctl.fast_idle_enable
      |=> !osc_run_o[`SCPM_OSC_FAST_RC] && !osc_run_o[`SCPM_OSC_FAST_XTAL])
    else $error("fast oscillator kept in halt without fast idle");
  a_stable_clear: assert property ($rose(osc_run_o[`SCPM_OSC_FAST_XTAL])
      |=> !stable[1])
    else $error("crystal stable flag not cleared at start");
  a_slow_wait: assert property ((act_sel != `SCPM_SEL_SLOW) && !slow_ok
      |=> (act_sel != `SCPM_SEL_SLOW))
    else $error("switched to fsub before it was stable");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_no_runt: assert property ($changed(act_sel) |-> !sysclk_o)
    else $error("tap changed while clock high");

  c_sleep: cover property ((mode == SCPM_RUN) ##1 (mode == SCPM_SLEEP));
  c_to_slow: cover property ($changed(act_sel) && (act_sel == `SCPM_SEL_SLOW));
  c_stable: cover property ($rose(stable[0]));
  c_idle_both: cover property (mode == SCPM_IDLE_BOTH_CLOCKS);

endmodule // scpm_ctrl

// ==== logic/scpm_pkg.sv ====
/*
 * types of the system clock and power mode controller.
 * assumes scpm_cfg.svh holds the numeric constants.
 */
package scpm_pkg;

  // system clock control register layout
  typedef struct packed {
    logic [2:0] sysclk_select;      // fh / 2^n, or fsub
    logic       reserved;           // reads zero
    logic       fast_source_select; // 0 rc, 1 crystal
    logic       slow_source_select; // 0 rc, 1 crystal
    logic       fast_idle_enable;   // keep fh during halt when its source's enable bit is set
    logic       slow_idle_enable;   // keep fsub during halt
  } scpm_sysclk_t;

  // power mode of the cpu
  typedef enum logic [2:0] {
    SCPM_RUN,
    SCPM_SLEEP,
    SCPM_IDLE_SLOW_ONLY,
    SCPM_IDLE_BOTH_CLOCKS,
    SCPM_IDLE_FAST_ONLY
  } scpm_mode_t;

endpackage

// ==== testbench/scpm_osc_model.sv ====
/*
 * oscillator bank model at the far side of the clock controller.
 * assumes osc_run_i comes from the controller on clk_i.
 */
`timescale 1ns/1ps

module scpm_osc_model #(
  parameter int READY_CYC = 20       // start-up time in clk cycles
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // enables in, levels and ready out
  input  wire logic [3:0] osc_run_i,
  output logic      [3:0] osc_level_o,
  output logic      [3:0] osc_ready_o
);
  // half periods in ns: fast rc, fast crystal, slow crystal, slow rc
  localparam int HALF [4] = '{60, 140, 400, 450};
  int cnt [4];                        // cycles since each enable rose

  // free oscillation; a stopped oscillator sits low, never at its last level
  for (genvar g = 0; g < 4; g++) begin : g_osc
    initial begin
      osc_level_o[g] = 1'b0;
      forever begin
        #(HALF[g]);
        osc_level_o[g] = osc_run_i[g] ? ~osc_level_o[g] : 1'b0;
      end
    end
  end

  // ready only after a full start-up with the enable held high
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i || !osc_run_i[i]) begin
        cnt[i] <= 0;
        osc_ready_o[i] <= 1'b0;
      end else if (cnt[i] < READY_CYC) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        osc_ready_o[i] <= 1'b1;
      end
    end
  end
endmodule // scpm_osc_model

// ==== testbench/tb_top.sv ====
/*
 * self-checking bench of the clock and power mode controller.
 * assumes scpm_osc_model stands in for the four oscillators.
 */
`timescale 1ns/1ps
`include "scpm_cfg.svh"

module tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, halt_i, wake_i, wdt_enable_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, osc_level_i, osc_ready_i, osc_run_o;
  logic [31:0] dat_i, dat_o;
  logic        ack_o, cpu_run_o, fast_crystal_range_o, sysclk_o, fh_periph_o, fsub_periph_o;
  logic [1:0]  fast_rc_freq_o;
  logic [7:0]  q;                     // scratch read data
  int          n_errors, checks, n;

  scpm_ctrl i_scpm_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .halt_i(halt_i), .wake_i(wake_i), .wdt_enable_i(wdt_enable_i), .cpu_run_o(cpu_run_o),
    .osc_level_i(osc_level_i), .osc_ready_i(osc_ready_i), .osc_run_o(osc_run_o),
    .fast_rc_freq_o(fast_rc_freq_o), .fast_crystal_range_o(fast_crystal_range_o),
    .sysclk_o(sysclk_o), .fh_periph_o(fh_periph_o), .fsub_periph_o(fsub_periph_o));
  scpm_osc_model i_scpm_osc_model (.clk_i(clk_i), .rst_i(rst_i), .osc_run_i(osc_run_o),
    .osc_level_o(osc_level_i), .osc_ready_o(osc_ready_i));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // classic single cycle; held until ack is sampled, no latency assumed
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) check("bus ack", ack_o, 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(a, 1'b0, 8'h00);
    check("register", q, exp);
  endtask

  task automatic wait_run(input int i, input logic v);
    int k;
    for (k = 0; osc_run_o[i] !== v && k < 400; k++) @(posedge clk_i);
    check("oscillator run", osc_run_o[i], v);
  endtask

  // rising edges of sysclk (0), fast periph (1) or slow periph (2)
  task automatic count(input int s, input int cyc);
    logic p, c;
    n = 0;
    p = 1'b0;
    repeat (cyc) begin
      @(posedge clk_i);
      #1;
      c = (s == 0) ? sysclk_o : (s == 1) ? fh_periph_o : fsub_periph_o;
      if (c && !p) n++;
      p = c;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(`SCPM_OFS_SYSCLK, 8'h00);
    rd(`SCPM_OFS_FAST_RC, 8'h03);
    rd(`SCPM_OFS_FAST_XTAL, 8'h00);
    rd(`SCPM_OFS_SLOW_XTAL, 8'h00);
    wb(8'h10, 1'b1, 8'hFF);
    rd(8'h10, 8'h00);
    wb(`SCPM_OFS_SYSCLK, 1'b1, 8'h10);
    rd(`SCPM_OFS_SYSCLK, 8'h00);
    wb(`SCPM_OFS_SLOW_XTAL, 1'b1, 8'hFE);
    rd(`SCPM_OFS_SLOW_XTAL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wb(`SCPM_OFS_FAST_RC, 1'b1, {4'hF, i[1:0], 2'h1});
      #1 check("rc freq", fast_rc_freq_o, (i == 3) ? 2'h0 : i[1:0]);
      rd(`SCPM_OFS_FAST_RC, {4'h0, i[1:0], 2'h3});
    end
    wb(`SCPM_OFS_FAST_RC, 1'b1, 8'h01);
    $display("test registers done");
  endtask

  task automatic t_xtal();
    wb(`SCPM_OFS_FAST_XTAL, 1'b1, 8'h04);
    #1 check("crystal range", fast_crystal_range_o, 1'b1);
    wb(`SCPM_OFS_FAST_XTAL, 1'b1, 8'h05);
    rd(`SCPM_OFS_FAST_XTAL, 8'h05);
    wait_run(1, 1'b1);
    repeat (40) @(posedge clk_i);
    rd(`SCPM_OFS_FAST_XTAL, 8'h07);
    wb(`SCPM_OFS_FAST_XTAL, 1'b1, 8'h00);
    rd(`SCPM_OFS_FAST_XTAL, 8'h04);
    wait_run(1, 1'b0);
    wb(`SCPM_OFS_FAST_XTAL, 1'b1, 8'h00);
    #1 check("crystal range", fast_crystal_range_o, 1'b0);
    wb(`SCPM_OFS_SLOW_XTAL, 1'b1, 8'h01);
    rd(`SCPM_OFS_SLOW_XTAL, 8'h01);
    wait_run(2, 1'b1);
    repeat (40) @(posedge clk_i);
    rd(`SCPM_OFS_SLOW_XTAL, 8'h03);
    wb(`SCPM_OFS_SLOW_XTAL, 1'b1, 8'h00);
    $display("test crystals done");
  endtask

  task automatic t_clksel();
    logic [7:0] v [10] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0,
                           8'hE0, 8'h28, 8'hE4};
    int per [10] = '{120, 240, 480, 960, 1920, 3840, 7680, 900, 560, 800};
    for (int i = 0; i < 10; i++) begin
      wb(`SCPM_OFS_SYSCLK, 1'b1, v[i]);
      repeat (per[i] / 25 + 60) @(posedge clk_i);
      count(0, per[i] * 4 / 50);
      check("sysclk edges", n >= 3 && n <= 5, 1'b1);
    end
    wb(`SCPM_OFS_SYSCLK, 1'b1, 8'h00);
    repeat (60) @(posedge clk_i);
    $display("test clock select done");
  endtask

  task automatic t_halt();
    logic [1:0] idl [5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
    logic       w   [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [3:0] er  [5] = '{4'h0, 4'h8, 4'h8, 4'h9, 4'h1};
    for (int i = 0; i < 5; i++) begin
      wdt_enable_i <= w[i];
      wb(`SCPM_OFS_SYSCLK, 1'b1, {6'h0, idl[i]});
      @(posedge clk_i);
      halt_i <= 1'b1;
      @(posedge clk_i);
      halt_i <= 1'b0;
      #1 check("cpu run", cpu_run_o, 1'b0);
      repeat (3) @(posedge clk_i);
      #1 check("halt osc run", osc_run_o, er[i]);
      count(1, 40);
      check("fast periph", n > 0, idl[i][1]);
      count(2, 40);
      check("slow periph", n > 0, idl[i][0]);
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      #1 check("cpu run", cpu_run_o, 1'b1);
      repeat (60) @(posedge clk_i);
    end
    wdt_enable_i <= 1'b0;
    $display("test halt modes done");
  endtask

  task automatic t_restart();
    wb(`SCPM_OFS_SYSCLK, 1'b1, 8'hE0);
    repeat (4) @(posedge clk_i);
    check("fast rc kept", osc_run_o[0], 1'b1);
    wb(`SCPM_OFS_FAST_RC, 1'b1, 8'h00);
    wait_run(0, 1'b0);
    wb(`SCPM_OFS_SYSCLK, 1'b1, 8'h00);
    wait_run(0, 1'b1);
    rd(`SCPM_OFS_FAST_RC, 8'h00);
    wb(`SCPM_OFS_FAST_RC, 1'b1, 8'h01);
    $display("test restart done");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // bounded run: the whole sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    {cyc_i, stb_i, we_i, halt_i, wake_i, wdt_enable_i} = '0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    t_regs();
    t_xtal();
    t_clksel();
    t_halt();
    t_restart();
    conclude();
  end
endmodule // tb_top
